/* bench/test_async_timer2_prescaler_waveform_ctrl.sv */
// Self-checking testbench for the timer clock source, prescaler and waveforms.
`timescale 1ns/100ps

module test_async_timer2_prescaler_waveform_ctrl;
	// Division ratio for each clock select code; zero means stopped.
	localparam int RATIO [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	logic CLK = 1'b0; // Bus and timer clock.
	logic RST_B = 1'b0; // Asynchronous reset, active low.
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic OSC_PIN_IN = 1'b0; // Level of the oscillator pin, driven here.
	logic OSC_PINS_DETACH;
	logic OSC_CRYSTAL_EN;
	logic EXT_CLOCK_BUF_EN;
	logic COMPARE_OUT_A;
	logic COMPARE_OUT_A_OVR;
	logic COMPARE_OUT_B;
	logic COMPARE_OUT_B_OVR;
	logic OVERFLOW_FLAG;
	int err_count = 0; // Mismatches seen.
	int num_checks = 0; // Comparisons made.
	logic [31:0] rdata; // Last word read over the bus.
	logic slverr; // Error response of the last transfer.

	// Clock at 50 MHz.
	always #10 CLK = ~CLK;

	timer2_core DUT (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .OSC_PIN_IN(OSC_PIN_IN),
		.OSC_PINS_DETACH(OSC_PINS_DETACH), .OSC_CRYSTAL_EN(OSC_CRYSTAL_EN),
		.EXT_CLOCK_BUF_EN(EXT_CLOCK_BUF_EN), .COMPARE_OUT_A(COMPARE_OUT_A),
		.COMPARE_OUT_A_OVR(COMPARE_OUT_A_OVR), .COMPARE_OUT_B(COMPARE_OUT_B),
		.COMPARE_OUT_B_OVR(COMPARE_OUT_B_OVR), .OVERFLOW_FLAG(OVERFLOW_FLAG));

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error: %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the request stands until PREADY is sampled high.
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] data);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= {2'b00, idx, 2'b00};
		PWDATA <= {24'h00_0000, data};
		@(posedge CLK);
		PENABLE <= 1'b1;
		// Values seen here at the edge are the ones the slave presented.
		@(posedge CLK);
		while (PREADY !== 1'b1 && n < 20) begin
			n++;
			@(posedge CLK);
		end
		if (n >= 20) begin
			chk("pready", 32'h1, 32'h0);
		end
		rdata = PRDATA;
		slverr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// Registers written at that edge settle before anyone looks at them.
		@(negedge CLK);
	endtask : xfer

	// Register write and read over the bus.
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		xfer(1'b1, idx, data);
	endtask : wr

	task automatic rd(input logic [7:0] idx);
		xfer(1'b0, idx, 8'h00);
	endtask : rd

	// Lets a number of clock cycles pass and settles on the falling edge.
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask : wait_cyc

	// Writes control B, which stops the timer when b selects no clock, and loads the counter with a start value.
	task automatic halt_load(input logic [7:0] b, input logic [7:0] cnt);
		wr(timer2_pkg::IDX_CTRL_B, b);
		wr(timer2_pkg::IDX_COUNT, cnt);
	endtask : halt_load

	// Reset values and the synchronous default source.
	task automatic t_reset;
		rd(timer2_pkg::IDX_CTRL_A);
		chk("ctrl_a reset", 32'h0, rdata);
		rd(timer2_pkg::IDX_ASYNC);
		chk("async reset", 32'h0, rdata);
		chk("detach reset", 32'h0, {31'h0, OSC_PINS_DETACH});
		$display("Test reset done");
	endtask : t_reset

	// Reserved bits of control A read zero; both pins are overridden.
	task automatic t_reserved;
		wr(timer2_pkg::IDX_CTRL_A, 8'hFF);
		rd(timer2_pkg::IDX_CTRL_A);
		chk("ctrl_a readback", 32'hF3, rdata);
		chk("ctrl_a slverr", 32'h0, {31'h0, slverr});
		// Pin direction is software's duty outside; override is what we see.
		chk("ovr a", 32'h1, {31'h0, COMPARE_OUT_A_OVR});
		chk("ovr b", 32'h1, {31'h0, COMPARE_OUT_B_OVR});
		wr(timer2_pkg::IDX_CTRL_A, 8'h00);
		$display("Test reserved done");
	endtask : t_reserved

	// Every clock select code, each after a prescaler clear.
	task automatic t_prescale;
		int lo;
		int hi;
		for (int cs = 0; cs < 8; cs++) begin
			halt_load(8'h00, 8'h00);
			wr(timer2_pkg::IDX_GEN_CTRL, 8'h01);
			wr(timer2_pkg::IDX_CTRL_B, 8'(cs));
			wait_cyc(cs == 0 ? 50 : 10 * RATIO[cs]);
			wr(timer2_pkg::IDX_CTRL_B, 8'h00);
			rd(timer2_pkg::IDX_COUNT);
			// Bus cycles around the run add a few ticks at ratio one.
			lo = (cs == 0) ? 0 : 9;
			hi = (cs == 0) ? 0 : ((cs == 1) ? 14 : 11);
			num_checks++;
			// An unknown count must fail, so the range test is made strict.
			if ((rdata <= hi && rdata >= lo) !== 1'b1) begin
				err_count++;
				$display("Error: count for select %0d expected %0d to %0d seen %0d",
					cs, lo, hi, rdata);
			end
		end
		$display("Test prescale done");
	endtask : t_prescale

	// Asynchronous source: pins detach and the pin edges clock the count.
	task automatic t_async;
		wr(timer2_pkg::IDX_ASYNC, 8'h20);
		chk("detach", 32'h1, {31'h0, OSC_PINS_DETACH});
		chk("crystal", 32'h1, {31'h0, OSC_CRYSTAL_EN});
		chk("ext buf", 32'h0, {31'h0, EXT_CLOCK_BUF_EN});
		wr(timer2_pkg::IDX_ASYNC, 8'h60);
		chk("ext buf on", 32'h1, {31'h0, EXT_CLOCK_BUF_EN});
		chk("crystal off", 32'h0, {31'h0, OSC_CRYSTAL_EN});
		halt_load(8'h01, 8'h00);
		// Five slow pin periods; the fast bus clock must not count.
		repeat (5) begin
			@(posedge CLK);
			OSC_PIN_IN <= 1'b1;
			repeat (2) @(posedge CLK);
			OSC_PIN_IN <= 1'b0;
			repeat (2) @(posedge CLK);
		end
		wait_cyc(4);
		wr(timer2_pkg::IDX_CTRL_B, 8'h00);
		rd(timer2_pkg::IDX_COUNT);
		chk("pin edge count", 32'h5, rdata);
		wr(timer2_pkg::IDX_ASYNC, 8'h00);
		chk("attach", 32'h0, {31'h0, OSC_PINS_DETACH});
		$display("Test async done");
	endtask : t_async

	// Set, clear and toggle on match for both channels in normal mode.
	task automatic t_nonpwm;
		logic [1:0] m [4];
		logic e [4];
		m = '{2'h3, 2'h2, 2'h1, 2'h1};
		e = '{1'b1, 1'b0, 1'b1, 1'b0};
		wr(timer2_pkg::IDX_CMP_A, 8'h05);
		wr(timer2_pkg::IDX_CMP_B, 8'h05);
		for (int i = 0; i < 4; i++) begin
			halt_load(8'h00, 8'h00);
			wr(timer2_pkg::IDX_CTRL_A, {m[i], m[i], 4'h0});
			wr(timer2_pkg::IDX_CTRL_B, 8'h01);
			wait_cyc(20);
			wr(timer2_pkg::IDX_CTRL_B, 8'h00);
			chk("out a", {31'h0, e[i]}, {31'h0, COMPARE_OUT_A});
			chk("out b", {31'h0, e[i]}, {31'h0, COMPARE_OUT_B});
		end
		wr(timer2_pkg::IDX_CTRL_A, 8'h00);
		chk("ovr a off", 32'h0, {31'h0, COMPARE_OUT_A_OVR});
		$display("Test nonpwm done");
	endtask : t_nonpwm

	// Overflow at MAX in normal mode and at TOP in mode seven.
	task automatic t_overflow;
		halt_load(8'h00, 8'hFD);
		wr(timer2_pkg::IDX_FLAGS, 8'h01);
		wr(timer2_pkg::IDX_CTRL_B, 8'h01);
		wait_cyc(10);
		chk("ovf at max", 32'h1, {31'h0, OVERFLOW_FLAG});
		wr(timer2_pkg::IDX_FLAGS, 8'h01);
		chk("ovf cleared", 32'h0, {31'h0, OVERFLOW_FLAG});
		// Compare A is loaded while updates are still immediate.
		wr(timer2_pkg::IDX_CMP_A, 8'h20);
		halt_load(8'h08, 8'h10);
		wr(timer2_pkg::IDX_CTRL_A, 8'h03);
		wr(timer2_pkg::IDX_FLAGS, 8'h01);
		wr(timer2_pkg::IDX_CTRL_B, 8'h09);
		wait_cyc(30);
		chk("ovf at top", 32'h1, {31'h0, OVERFLOW_FLAG});
		halt_load(8'h00, 8'h00);
		wr(timer2_pkg::IDX_CTRL_A, 8'h00);
		wr(timer2_pkg::IDX_FLAGS, 8'h01);
		$display("Test overflow done");
	endtask : t_overflow

	// Fast PWM with TOP at 0xFF, non-inverting then inverting.
	task automatic t_fastpwm;
		logic lvl;
		wr(timer2_pkg::IDX_CMP_A, 8'h40);
		wr(timer2_pkg::IDX_CMP_B, 8'h40);
		for (int inv = 0; inv < 2; inv++) begin
			lvl = (inv == 0);
			halt_load(8'h00, 8'hF0);
			wr(timer2_pkg::IDX_CTRL_A, (inv == 0) ? 8'hA3 : 8'hF3);
			wr(timer2_pkg::IDX_CTRL_B, 8'h01);
			wait_cyc(30);
			chk("pwm a bottom", {31'h0, lvl}, {31'h0, COMPARE_OUT_A});
			chk("pwm b bottom", {31'h0, lvl}, {31'h0, COMPARE_OUT_B});
			wait_cyc(64);
			chk("pwm a match", {31'h0, !lvl}, {31'h0, COMPARE_OUT_A});
			chk("pwm b match", {31'h0, !lvl}, {31'h0, COMPARE_OUT_B});
		end
		halt_load(8'h00, 8'h00);
		$display("Test fastpwm done");
	endtask : t_fastpwm

	// Phase correct PWM: clear on the up-count match, set on the way down.
	task automatic t_phase;
		halt_load(8'h00, 8'h30);
		wr(timer2_pkg::IDX_CTRL_A, 8'hA1);
		wr(timer2_pkg::IDX_CTRL_B, 8'h01);
		wait_cyc(30);
		chk("phase a up", 32'h0, {31'h0, COMPARE_OUT_A});
		chk("phase b up", 32'h0, {31'h0, COMPARE_OUT_B});
		// Up to 0xFF and back down past 0x40 takes about 370 more ticks.
		wait_cyc(420);
		chk("phase a down", 32'h1, {31'h0, COMPARE_OUT_A});
		chk("phase b down", 32'h1, {31'h0, COMPARE_OUT_B});
		halt_load(8'h00, 8'h00);
		wr(timer2_pkg::IDX_CTRL_A, 8'h00);
		$display("Test phase done");
	endtask : t_phase

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// Main sequence: reset for four cycles, then every scenario.
	initial begin
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		t_reset();
		t_reserved();
		t_prescale();
		t_async();
		t_nonpwm();
		t_overflow();
		t_fastpwm();
		t_phase();
		wrap_up();
	end

	// Watchdog: the tests need about 17000 cycles, so 60000 means a hang.
	initial begin
		repeat (60000) @(posedge CLK);
		err_count++;
		$display("Error: watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule : test_async_timer2_prescaler_waveform_ctrl

/* design/timer2_core.sv */
// Timer 2 clock source, prescaler, counter and waveform control with APB.
//
// Behaviour
// - Reset selects I/O clock, synchronous source.
// - Async select takes source from oscillator pin.
// - Async select detaches both oscillator pins.
// - External clock bit enables external clock buffer when async is selected.
// - Prescaler taps 8 to 1024, direct, stop.
// - Prescaler reset bit clears prescaler count.
// - Nonzero channel A mode overrides pin.
// - Non-PWM A: off, toggle, clear, set.
// - Fast PWM A actions, toggle needs top select.
// - Phase PWM A actions, toggle needs top select.
// - Channel B override and non-PWM actions.
// - Fast PWM B actions, 0,1 reserved.
// - Phase PWM B actions, 0,1 reserved.
// - Fast PWM compare at TOP acts at BOTTOM.
// - Phase PWM compare at TOP acts at TOP.
// - Control A bits 3:2 read zero.
// - Waveform mode sets sequence and TOP.
// - Compare update immediate, TOP or BOTTOM; fast PWM updates at TOP here, never at BOTTOM.
// - Overflow flag at MAX, BOTTOM or TOP.
// - Clock select field encoding 0 to 7.
`timescale 1ns/100ps

// One compare channel: active compare value and its output waveform.
module compare_channel #(
	parameter bit TOGGLE_IN_PWM = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic update,
	input wire logic [7:0] cmp_buf,
	input wire logic [7:0] cnt,
	input wire logic [7:0] top,
	input wire logic [1:0] out_mode,
	input wire timer2_pkg::wave_e wave,
	input wire logic dir_up,
	input wire logic top_sel,
	output logic [7:0] cmp_act,
	output logic pin_val
);
	// A match is seen on a timer tick while the count equals the value.
	wire logic match = tick && (cnt == cmp_act);
	wire logic at_top = tick && (cnt == top);
	// The compare value equals TOP with the high mode bit set.
	wire logic special = out_mode[1] && (cmp_act == top);
	// Toggling in PWM kinds is only allowed on a capable channel.
	wire logic may_toggle = TOGGLE_IN_PWM && top_sel;
	logic next_pin;

	// Output action chosen from waveform kind and output mode.
	always_comb begin
		next_pin = pin_val;
		case (wave)
			timer2_pkg::WAVE_FAST: begin
				if (out_mode == 2'b01) begin
					if (match && may_toggle) begin
						next_pin = ~pin_val;
					end
				end else if (out_mode[1]) begin
					// Wrap to BOTTOM wins over a match at TOP.
					if (at_top) begin
						next_pin = ~out_mode[0];
					end else if (match && !special) begin
						next_pin = out_mode[0];
					end
				end
			end
			timer2_pkg::WAVE_PHASE: begin
				if (out_mode == 2'b01) begin
					if (match && may_toggle) begin
						next_pin = ~pin_val;
					end
				end else if (out_mode[1]) begin
					if (special) begin
						if (at_top) begin
							next_pin = ~out_mode[0];
						end
					end else if (match) begin
						next_pin = dir_up ? out_mode[0] : ~out_mode[0];
					end
				end
			end
			default: begin
				// Non-PWM kinds: toggle, clear or set on match.
				if (match) begin
					case (out_mode)
						2'b01: next_pin = ~pin_val;
						2'b10: next_pin = 1'b0;
						2'b11: next_pin = 1'b1;
						default: next_pin = pin_val;
					endcase
				end
			end
		endcase
	end

	// Active compare register follows the buffer only at update moments.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmp_act <= timer2_pkg::BYTE_RESET;
			pin_val <= 1'b0;
		end else begin
			if (update) begin
				cmp_act <= cmp_buf;
			end
			pin_val <= next_pin;
		end
	end
endmodule : compare_channel

// Top of the timer: register slave, clock source, prescaler and counter.
module timer2_core (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic OSC_PIN_IN,
	output logic OSC_PINS_DETACH,
	output logic OSC_CRYSTAL_EN,
	output logic EXT_CLOCK_BUF_EN,
	output logic COMPARE_OUT_A,
	output logic COMPARE_OUT_A_OVR,
	output logic COMPARE_OUT_B,
	output logic COMPARE_OUT_B_OVR,
	output logic OVERFLOW_FLAG
);
	// Software registers.
	timer2_pkg::ctrl_a_s ctrl_a;
	timer2_pkg::ctrl_b_s ctrl_b;
	logic [7:0] cnt; // Live counter value.
	logic [7:0] cmp_buf_a; // Compare A as written by software.
	logic [7:0] cmp_buf_b; // Compare B as written by software.
	logic async_clock_select;
	logic external_clock_enable;
	logic overflow_flag;
	logic [9:0] prescaler; // Free-running division counter.
	logic osc_prev; // Last sampled oscillator pin level.
	timer2_pkg::dir_e dir; // Phase correct counting direction.
	logic [31:0] read_word;
	logic [7:0] cmp_act_a;
	logic [7:0] cmp_act_b;
	logic [7:0] next_cnt;
	timer2_pkg::dir_e next_dir;

	// Bus phases: registers change only at the completing access edge.
	wire logic setup = PSEL && !PENABLE;
	wire logic access = PSEL && PENABLE;
	wire logic wr = access && PWRITE;
	wire logic [9:0] idx = PADDR[11:2];
	wire logic hit_a = idx == {2'b00, timer2_pkg::IDX_CTRL_A};
	wire logic hit_b = idx == {2'b00, timer2_pkg::IDX_CTRL_B};
	wire logic hit_cnt = idx == {2'b00, timer2_pkg::IDX_COUNT};
	wire logic hit_ca = idx == {2'b00, timer2_pkg::IDX_CMP_A};
	wire logic hit_cb = idx == {2'b00, timer2_pkg::IDX_CMP_B};
	wire logic hit_as = idx == {2'b00, timer2_pkg::IDX_ASYNC};
	wire logic hit_gen = idx == {2'b00, timer2_pkg::IDX_GEN_CTRL};
	wire logic hit_fl = idx == {2'b00, timer2_pkg::IDX_FLAGS};
	wire logic mapped = hit_a || hit_b || hit_cnt || hit_ca || hit_cb ||
		hit_as || hit_gen || hit_fl;
	// Sub-word byte offsets are refused as well.
	wire logic good = mapped && (PADDR[1:0] == 2'b00);
	wire logic [7:0] wbyte = PWDATA[7:0];

	// The slave always answers in the access phase.
	assign PREADY = access;
	assign PSLVERR = access && !good;

	// Read multiplexer; reserved bits and strobe bits read as zero.
	assign read_word =
		hit_a ? {24'h000000, ctrl_a.chan_a_output_mode,
			ctrl_a.chan_b_output_mode, 2'b00,
			ctrl_a.waveform_mode_low} :
		hit_b ? {24'h000000, 4'h0, ctrl_b.top_select_mode_bit,
			ctrl_b.clock_select_field} :
		hit_cnt ? {24'h000000, cnt} :
		hit_ca ? {24'h000000, cmp_buf_a} :
		hit_cb ? {24'h000000, cmp_buf_b} :
		hit_as ? {24'h000000, 1'b0, external_clock_enable,
			async_clock_select, 5'h00} :
		hit_fl ? {31'h00000000, overflow_flag} :
		32'h00000000;

	// Read data is captured in the setup cycle and stands through access.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA <= 32'h00000000;
		end else if (setup && !PWRITE) begin
			PRDATA <= good ? read_word : 32'h00000000;
		end
	end

	// Configuration registers written at the access edge.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_a <= timer2_pkg::CTRL_RESET;
			ctrl_b <= timer2_pkg::CTRL_RESET;
			cmp_buf_a <= timer2_pkg::BYTE_RESET;
			cmp_buf_b <= timer2_pkg::BYTE_RESET;
			async_clock_select <= 1'b0;
			external_clock_enable <= 1'b0;
		end else if (wr && good) begin
			if (hit_a) begin
				ctrl_a <= {wbyte[7:4], 2'b00, wbyte[1:0]};
			end
			if (hit_b) begin
				ctrl_b <= {4'h0, wbyte[3:0]};
			end
			if (hit_ca) begin
				cmp_buf_a <= wbyte;
			end
			if (hit_cb) begin
				cmp_buf_b <= wbyte;
			end
			if (hit_as) begin
				async_clock_select <= wbyte[timer2_pkg::ASYNC_SEL_BIT];
				external_clock_enable <= wbyte[timer2_pkg::EXT_CLK_BIT];
			end
		end
	end

	// Pin control for the oscillator pair.
	assign OSC_PINS_DETACH = async_clock_select;
	// The crystal only runs while no external clock is requested.
	assign OSC_CRYSTAL_EN = async_clock_select && !external_clock_enable;
	assign EXT_CLOCK_BUF_EN = async_clock_select &&
		external_clock_enable;

	// Source tick: every I/O clock, or each rising oscillator pin edge.
	// The pin is taken as synchronous, so a lone edge register suffices;
	// it must run well below the I/O clock for no edge to be missed.
	wire logic osc_rise = OSC_PIN_IN && !osc_prev;
	wire logic src_tick = async_clock_select ? osc_rise : 1'b1;
	wire logic psr_write = wr && good && hit_gen && wbyte[timer2_pkg::PSR_BIT];

	// Prescaler advances on each source tick; a reset write clears it.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			prescaler <= timer2_pkg::PRE_RESET;
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= OSC_PIN_IN;
			if (psr_write) begin
				prescaler <= timer2_pkg::PRE_RESET;
			end else if (src_tick) begin
				prescaler <= prescaler + 10'h001;
			end
		end
	end

	// Tap mask for the selected ratio; stop gives no tick at all.
	wire logic [2:0] cs = ctrl_b.clock_select_field;
	wire logic [9:0] tap_mask =
		(cs == 3'h2) ? timer2_pkg::MASK_8 :
		(cs == 3'h3) ? timer2_pkg::MASK_32 :
		(cs == 3'h4) ? timer2_pkg::MASK_64 :
		(cs == 3'h5) ? timer2_pkg::MASK_128 :
		(cs == 3'h6) ? timer2_pkg::MASK_256 :
		timer2_pkg::MASK_1024;
	wire logic tap_hit = (prescaler & tap_mask) == tap_mask;
	wire logic timer_tick = (cs == timer2_pkg::CS_STOP) ? 1'b0 :
		(cs == timer2_pkg::CS_DIRECT) ? src_tick :
		(src_tick && tap_hit);

	// Mode decode from the three waveform bits.
	wire logic [2:0] wmode = {ctrl_b.top_select_mode_bit,
		ctrl_a.waveform_mode_low};
	wire logic is_phase = (wmode == timer2_pkg::WM_PC_FF) ||
		(wmode == timer2_pkg::WM_PC_CMP);
	wire logic is_fast = (wmode == timer2_pkg::WM_FAST_FF) ||
		(wmode == timer2_pkg::WM_FAST_CMP);
	wire logic top_from_cmp = (wmode == timer2_pkg::WM_CTC) ||
		(wmode == timer2_pkg::WM_PC_CMP) ||
		(wmode == timer2_pkg::WM_FAST_CMP);
	wire logic [7:0] top = top_from_cmp ? cmp_act_a :
		timer2_pkg::CNT_MAX;
	wire timer2_pkg::wave_e wave = is_fast ? timer2_pkg::WAVE_FAST :
		is_phase ? timer2_pkg::WAVE_PHASE : timer2_pkg::WAVE_PLAIN;
	wire logic dir_up = dir == timer2_pkg::DIR_UP;
	wire logic at_top = timer_tick && (cnt == top);
	wire logic at_bottom_down = timer_tick && !dir_up &&
		(cnt == timer2_pkg::CNT_BOTTOM);
	// Compare updates: immediate, or at TOP in both phase and fast.
	wire logic cmp_update = is_phase ? at_top :
		is_fast ? at_top : 1'b1;

	// Next count and direction per counting sequence.
	always_comb begin
		next_cnt = cnt;
		next_dir = dir;
		if (timer_tick) begin
			if (is_phase) begin
				if (dir_up && (cnt >= top)) begin
					next_dir = timer2_pkg::DIR_DOWN;
					next_cnt = cnt - 8'h01;
				end else if (!dir_up && (cnt == timer2_pkg::CNT_BOTTOM)) begin
					next_dir = timer2_pkg::DIR_UP;
					next_cnt = cnt + 8'h01;
				end else begin
					next_cnt = dir_up ? cnt + 8'h01 : cnt - 8'h01;
				end
			end else if (cnt == top) begin
				next_dir = timer2_pkg::DIR_UP;
				next_cnt = timer2_pkg::CNT_BOTTOM;
			end else begin
				next_dir = timer2_pkg::DIR_UP;
				next_cnt = cnt + 8'h01;
			end
		end
	end

	// Overflow moment per mode group.
	wire logic ovf_event = is_phase ? at_bottom_down :
		(wmode == timer2_pkg::WM_FAST_CMP) ? at_top :
		(timer_tick && (cnt == timer2_pkg::CNT_MAX));
	wire logic ovf_clear = wr && good && hit_fl &&
		wbyte[timer2_pkg::OVF_BIT];

	// Counter, direction and sticky overflow; a software count write wins.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt <= timer2_pkg::BYTE_RESET;
			dir <= timer2_pkg::DIR_UP;
			overflow_flag <= 1'b0;
		end else begin
			cnt <= (wr && good && hit_cnt) ? wbyte : next_cnt;
			dir <= next_dir;
			// Setting beats clearing in the same cycle.
			overflow_flag <= ovf_event || (overflow_flag && !ovf_clear);
		end
	end
	assign OVERFLOW_FLAG = overflow_flag;

	// Channel A may toggle in PWM kinds; channel B may not.
	compare_channel #(.TOGGLE_IN_PWM(1'b1)) u_chan_a (
		.clk(CLK),
		.rst_b(RST_B),
		.tick(timer_tick),
		.update(cmp_update),
		.cmp_buf(cmp_buf_a),
		.cnt(cnt),
		.top(top),
		.out_mode(ctrl_a.chan_a_output_mode),
		.wave(wave),
		.dir_up(dir_up),
		.top_sel(ctrl_b.top_select_mode_bit),
		.cmp_act(cmp_act_a),
		.pin_val(COMPARE_OUT_A)
	);
	compare_channel #(.TOGGLE_IN_PWM(1'b0)) u_chan_b (
		.clk(CLK),
		.rst_b(RST_B),
		.tick(timer_tick),
		.update(cmp_update),
		.cmp_buf(cmp_buf_b),
		.cnt(cnt),
		.top(top),
		.out_mode(ctrl_a.chan_b_output_mode),
		.wave(wave),
		.dir_up(dir_up),
		.top_sel(ctrl_b.top_select_mode_bit),
		.cmp_act(cmp_act_b),
		.pin_val(COMPARE_OUT_B)
	);

	// Pin override follows any nonzero output mode in every waveform mode.
	assign COMPARE_OUT_A_OVR = |ctrl_a.chan_a_output_mode;
	assign COMPARE_OUT_B_OVR = |ctrl_a.chan_b_output_mode;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sync_source_a: assert property (!async_clock_select |-> src_tick)
		else $error("synchronous source does not tick every cycle");
	async_source_a: assert property (
		async_clock_select && !(OSC_PIN_IN && !osc_prev) |-> !src_tick)
		else $error("asynchronous source ticks without a pin edge");
	pin_detach_a: assert property (
		wr && good && hit_as && wbyte[timer2_pkg::ASYNC_SEL_BIT]
		|=> OSC_PINS_DETACH && !OSC_CRYSTAL_EN == EXT_CLOCK_BUF_EN)
		else $error("oscillator pins not detached after async select");
	psr_clear_a: assert property (psr_write |=> prescaler == 10'h000)
		else $error("prescaler not cleared by reset write");
	stop_tick_a: assert property (
		ctrl_b.clock_select_field == timer2_pkg::CS_STOP |-> !timer_tick)
		else $error("timer ticks while stopped");
	div8_tick_a: assert property (
		timer_tick && cs == 3'h2 |-> prescaler[2:0] == 3'h7 && src_tick)
		else $error("divide by eight tick off phase");
	ctrl_rsvd_a: assert property (
		setup && !PWRITE && hit_a && good |=> PRDATA[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");
	mode_override_a: assert property (
		wr && good && hit_a && wbyte[7:6] != 2'b00 |=> COMPARE_OUT_A_OVR)
		else $error("channel A does not override pin");
	ctc_wrap_a: assert property (
		wmode == timer2_pkg::WM_CTC && timer_tick && cnt == cmp_act_a &&
		!(wr && hit_cnt) |=> cnt == 8'h00)
		else $error("clear on match did not wrap to zero");
	ovf_max_a: assert property (
		wmode == timer2_pkg::WM_NORMAL && timer_tick && cnt == 8'hFF
		|=> overflow_flag ##0 $past(cnt) == 8'hFF)
		else $error("overflow flag not set at MAX");
	imm_update_a: assert property (
		wmode == timer2_pkg::WM_NORMAL && wr && good && hit_ca
		|=> ##1 cmp_act_a == $past(wbyte, 2))
		else $error("compare A not updated immediately");
	nonpwm_set_a: assert property (
		wave == timer2_pkg::WAVE_PLAIN && ctrl_a.chan_a_output_mode == 2'b11 &&
		timer_tick && cnt == cmp_act_a |=> COMPARE_OUT_A)
		else $error("channel A not set on match");

	fast_pwm_c: cover property (is_fast && at_top ##1 COMPARE_OUT_A);
	phase_turn_c: cover property (is_phase && at_top ##1 !dir_up);
	async_tick_c: cover property (async_clock_select && timer_tick);
	ovf_clear_c: cover property (overflow_flag ##1 !overflow_flag);
endmodule : timer2_core

/* design/timer2_pkg.sv */
// Package of offsets, fields, reset values and types for the timer block.
package timer2_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CTRL_A = 8'hB0;
	localparam logic [7:0] IDX_CTRL_B = 8'hB1;
	localparam logic [7:0] IDX_COUNT = 8'hB2;
	localparam logic [7:0] IDX_CMP_A = 8'hB3;
	localparam logic [7:0] IDX_CMP_B = 8'hB4;
	localparam logic [7:0] IDX_ASYNC = 8'hB6;
	localparam logic [7:0] IDX_GEN_CTRL = 8'hC0;
	localparam logic [7:0] IDX_FLAGS = 8'hC1;
	// Field positions in the asynchronous status, general and flag registers.
	localparam int EXT_CLK_BIT = 6;
	localparam int ASYNC_SEL_BIT = 5;
	localparam int PSR_BIT = 0;
	localparam int OVF_BIT = 0;
	// Reset values of the software-visible registers and the prescaler.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [9:0] PRE_RESET = 10'h000;
	// Counter extremes.
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	// Prescaler tap masks for clock select values 2 to 7.
	localparam logic [9:0] MASK_8 = 10'h007;
	localparam logic [9:0] MASK_32 = 10'h01F;
	localparam logic [9:0] MASK_64 = 10'h03F;
	localparam logic [9:0] MASK_128 = 10'h07F;
	localparam logic [9:0] MASK_256 = 10'h0FF;
	localparam logic [9:0] MASK_1024 = 10'h3FF;
	// Clock select codes.
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	// Waveform modes as {top select, low bits}.
	localparam logic [2:0] WM_NORMAL = 3'h0;
	localparam logic [2:0] WM_PC_FF = 3'h1;
	localparam logic [2:0] WM_CTC = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PC_CMP = 3'h5;
	localparam logic [2:0] WM_FAST_CMP = 3'h7;
	// Control register A layout.
	typedef struct packed {
		logic [1:0] chan_a_output_mode;
		logic [1:0] chan_b_output_mode;
		logic [1:0] rsvd;
		logic [1:0] waveform_mode_low;
	} ctrl_a_s;
	// Control register B layout.
	typedef struct packed {
		logic [1:0] force_rsvd;
		logic [1:0] rsvd;
		logic top_select_mode_bit;
		logic [2:0] clock_select_field;
	} ctrl_b_s;
	// One-hot kind of waveform.
	typedef enum logic [2:0] {
		WAVE_PLAIN = 3'b001,
		WAVE_FAST = 3'b010,
		WAVE_PHASE = 3'b100
	} wave_e;
	// One-hot counting direction.
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_e;
endpackage : timer2_pkg
